// File: bench/ccpb_clock_power_properties.sv
// Port-level assertions for the bring-up sequencer
`timescale 1ns/1ns
module ccpb_clock_power_properties #(
  parameter int LOCK_BIT_CYC = 4
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic COMMON_BIAS_ENABLE_I,
  input wire logic PLL_POWER_ENABLE_I,
  input wire logic MASTER_CLOCK_OUT_ENABLE_I,
  input wire logic ADC_LEFT_POWER_I,
  input wire logic ADC_RIGHT_POWER_I,
  input wire logic AUTO_LEVEL_ENABLE_I,
  input wire logic [15:0] DAC_SAMPLE_I,
  input wire logic MASTER_CLOCK_OE_O,
  input wire logic BIT_CLOCK_OE_O,
  input wire logic [2:0] CLOCK_MODE_O,
  input wire logic LOCK_VALID_O,
  input wire logic NORMAL_OPERATION_O,
  input wire logic ADC_INIT_BUSY_O,
  input wire logic ADC_DATA_VALID_O,
  input wire logic AUTO_LEVEL_ACTIVE_O,
  input wire logic [7:0] INPUT_VOLUME_GAIN_O,
  input wire logic [15:0] DAC_LEVEL_O
);
  int run_cnt;
  wire logic adc_off = !ADC_LEFT_POWER_I && !ADC_RIGHT_POWER_I;
  // Cycles the PLL has been asked to run; the fastest lock still needs more
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      run_cnt <= 0;
    end else begin
      run_cnt <= (COMMON_BIAS_ENABLE_I && PLL_POWER_ENABLE_I) ? run_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Relations between controls and outputs
  property p_dac;
    1 |=> DAC_LEVEL_O == {~$past(DAC_SAMPLE_I[15]), $past(DAC_SAMPLE_I[14:0])};
  endproperty
  property p_bias;
    !COMMON_BIAS_ENABLE_I |=> !(MASTER_CLOCK_OE_O || BIT_CLOCK_OE_O || NORMAL_OPERATION_O
      || ADC_INIT_BUSY_O);
  endproperty
  property p_lock_min;
    $rose(LOCK_VALID_O) |-> run_cnt > LOCK_BIT_CYC;
  endproperty
  property p_lock_drop;
    !PLL_POWER_ENABLE_I |-> ##2 !LOCK_VALID_O;
  endproperty
  property p_master;
    BIT_CLOCK_OE_O && CLOCK_MODE_O == ccpb_pkg::CCPB_PLL_MASTER && $stable(CLOCK_MODE_O)
      |-> LOCK_VALID_O;
  endproperty
  property p_mclk;
    MASTER_CLOCK_OE_O |-> $past(MASTER_CLOCK_OUT_ENABLE_I && PLL_POWER_ENABLE_I);
  endproperty
  property p_alc_off;
    adc_off |=> !AUTO_LEVEL_ACTIVE_O;
  endproperty
  property p_gain_hold;
    (adc_off && AUTO_LEVEL_ENABLE_I) [*3] |-> $stable(INPUT_VOLUME_GAIN_O);
  endproperty
  property p_busy;
    ADC_INIT_BUSY_O |-> !AUTO_LEVEL_ACTIVE_O && !ADC_DATA_VALID_O;
  endproperty
  a_dac: assert property (p_dac) else $error("dac level wrong");
  a_bias: assert property (p_bias) else $error("active without bias");
  a_lock_min: assert property (p_lock_min) else $error("lock too early");
  a_lock_drop: assert property (p_lock_drop) else $error("lock kept");
  a_master: assert property (p_master) else $error("clocks before lock");
  a_mclk: assert property (p_mclk) else $error("mclk out unasked");
  a_alc_off: assert property (p_alc_off) else $error("level control on");
  a_gain_hold: assert property (p_gain_hold) else $error("gain moved");
  a_busy: assert property (p_busy) else $error("busy overlap");
  c_lock: cover property ($rose(LOCK_VALID_O));
  c_init: cover property ($fell(ADC_INIT_BUSY_O));
  c_alc: cover property ($rose(AUTO_LEVEL_ACTIVE_O));
endmodule : ccpb_clock_power_properties

bind ccpb_clock_power ccpb_clock_power_properties #(.LOCK_BIT_CYC(LOCK_BIT_CYC)) u_props (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .COMMON_BIAS_ENABLE_I(COMMON_BIAS_ENABLE_I),
  .PLL_POWER_ENABLE_I(PLL_POWER_ENABLE_I), .MASTER_CLOCK_OUT_ENABLE_I(MASTER_CLOCK_OUT_ENABLE_I),
  .ADC_LEFT_POWER_I(ADC_LEFT_POWER_I), .ADC_RIGHT_POWER_I(ADC_RIGHT_POWER_I),
  .AUTO_LEVEL_ENABLE_I(AUTO_LEVEL_ENABLE_I), .DAC_SAMPLE_I(DAC_SAMPLE_I),
  .MASTER_CLOCK_OE_O(MASTER_CLOCK_OE_O), .BIT_CLOCK_OE_O(BIT_CLOCK_OE_O),
  .CLOCK_MODE_O(CLOCK_MODE_O), .LOCK_VALID_O(LOCK_VALID_O),
  .NORMAL_OPERATION_O(NORMAL_OPERATION_O), .ADC_INIT_BUSY_O(ADC_INIT_BUSY_O),
  .ADC_DATA_VALID_O(ADC_DATA_VALID_O), .AUTO_LEVEL_ACTIVE_O(AUTO_LEVEL_ACTIVE_O),
  .INPUT_VOLUME_GAIN_O(INPUT_VOLUME_GAIN_O), .DAC_LEVEL_O(DAC_LEVEL_O));

// File: bench/ccpb_clock_power_tb_top.sv
// Self-checking bench for the bring-up sequencer
`timescale 1ns/1ns
module ccpb_clock_power_tb_top;
  localparam int LM = 8;
  localparam int LF = 16;
  localparam int LB = 4;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic bias = 1'h0, pll = 1'h0, mce = 1'h0, ms = 1'h0, adl = 1'h0, adr = 1'h0;
  logic auto_level_enable = 1'h0, up = 1'h0, dn = 1'h0, wr = 1'h0, run = 1'h0;
  logic [1:0] rs = 2'h0;
  logic [15:0] dac = 16'h0000;
  logic mh, bh, fh, mo, mp, moe, fo, foe, bo, boe, lock, norm, busy, dv, act;
  logic [2:0] mode;
  logic [7:0] gain;
  logic [15:0] lvl;
  logic [15:0] dsm [4] = '{16'h7fff, 16'h8000, 16'h0000, 16'hffff};
  logic [15:0] dex [4] = '{16'hffff, 16'h0000, 16'h8000, 16'h7fff};
  logic [7:0] mt [6] = '{8'h00, 8'h41, 8'hc2, 8'h93, 8'ha4, 8'h85};
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  // Free-running system clock
  always #5 clk = ~clk;
  ccpb_host_clocks host (.clk_i(clk), .run_i(run), .mclk_o(mh), .bclk_o(bh), .fclk_o(fh));
  // Pins resolved from whichever side drives them
  ccpb_clock_power #(.LOCK_MCLK_CYC(LM), .LOCK_FRAME_CYC(LF), .LOCK_BIT_CYC(LB)) dut (
    .CLK_I(clk), .RSTN_I(rstn), .COMMON_BIAS_ENABLE_I(bias), .PLL_POWER_ENABLE_I(pll),
    .MASTER_CLOCK_OUT_ENABLE_I(mce), .MASTER_SELECT_I(ms), .PLL_REFERENCE_SEL_I(rs),
    .BIT_CLOCK_RATE_SEL_I(1'h1), .ADC_LEFT_POWER_I(adl), .ADC_RIGHT_POWER_I(adr),
    .AUTO_LEVEL_ENABLE_I(auto_level_enable), .GAIN_UP_I(up), .GAIN_DOWN_I(dn), .GAIN_WRITE_I(wr),
    .GAIN_VALUE_I(8'h40), .DAC_SAMPLE_I(dac), .MASTER_CLOCK_INPUT_I(mh),
    .FRAME_CLOCK_I(foe ? fo : fh), .BIT_CLOCK_I(boe ? bo : bh), .MASTER_CLOCK_O(mo),
    .MASTER_CLOCK_OE_O(moe), .FRAME_CLOCK_O(fo), .FRAME_CLOCK_OE_O(foe), .BIT_CLOCK_O(bo),
    .BIT_CLOCK_OE_O(boe), .CLOCK_MODE_O(mode), .LOCK_VALID_O(lock),
    .NORMAL_OPERATION_O(norm), .ADC_INIT_BUSY_O(busy), .ADC_DATA_VALID_O(dv),
    .AUTO_LEVEL_ACTIVE_O(act), .INPUT_VOLUME_GAIN_O(gain), .DAC_LEVEL_O(lvl));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // Bias last, so the count starts at a known edge; n holds cycles to lock
  task automatic lock_time(input logic [1:0] r, input logic m);
    rs = r;
    ms = m;
    pll = 1'h1;
    tick(10);
    chk("lock no bias", 16'(lock), 16'h0000);
    bias = 1'h1;
    n = 0;
    while (lock !== 1'h1 && n < 100) begin
      tick(1);
      n++;
    end
  endtask : lock_time
  task automatic all_off;
    bias = 1'h0;
    pll = 1'h0;
    ms = 1'h0;
    tick(3);
  endtask : all_off
  // Hang guard, well above the longest init run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    tick(15);
    rstn = 1'h1;
    tick(1);
    chk("gain reset", 16'(gain), 16'h00e1);
    for (int i = 0; i < 4; i++) begin
      dac = dsm[i];
      tick(1);
      chk("dac level", lvl, dex[i]);
    end
    for (int i = 0; i < 6; i++) begin
      {pll, ms, rs} = mt[i][7:4];
      tick(1);
      chk("mode", 16'(mode), 16'(mt[i][2:0]));
    end
    $display("reset and mode test done");
    all_off();
    run = 1'h1;
    tick(20);
    lock_time(2'h2, 1'h0);
    chk("lock bit", 16'(n), 16'(LB + 1));
    chk("normal slave", 16'(norm), 16'h0001);
    all_off();
    lock_time(2'h1, 1'h0);
    chk("lock frame", 16'(n), 16'(LF + 1));
    all_off();
    mce = 1'h1;
    lock_time(2'h0, 1'h0);
    chk("lock mclk", 16'(n), 16'(LM + 1));
    chk("mclk oe slave", 16'(moe), 16'h0001);
    all_off();
    lock_time(2'h0, 1'h1);
    chk("lock master", 16'(n), 16'(LM + 1));
    chk("frame oe", 16'(foe), 16'h0001);
    chk("mclk oe", 16'(moe), 16'h0001);
    // After lock the output runs at the fast tap, so it flips every cycle
    mp = mo;
    tick(1);
    chk("mclk toggle", 16'(mo ^ mp), 16'h0001);
    all_off();
    mce = 1'h0;
    $display("lock test done");
    ms = 1'h1;
    bias = 1'h1;
    tick(8);
    chk("ext master oe", 16'(boe), 16'h0001);
    all_off();
    run = 1'h0;
    tick(1100);
    bias = 1'h1;
    tick(20);
    chk("slave no clocks", 16'(norm), 16'h0000);
    run = 1'h1;
    tick(20);
    chk("slave clocks", 16'(norm), 16'h0001);
    $display("external mode test done");
    auto_level_enable = 1'h1;
    adl = 1'h1;
    tick(1);
    n = 0;
    while (busy === 1'h1 && n < 20000) begin
      tick(1);
      n++;
    end
    // First frame edge may fall anywhere in the first period after power-up
    chk("init span", 16'(n >= 1058 * 16 && n <= 1059 * 16 + 4), 16'h0001);
    tick(1);
    chk("alc start", 16'(act), 16'h0001);
    chk("data valid", 16'(dv), 16'h0001);
    chk("alc gain", 16'(gain), 16'h00e1);
    dn = 1'h1;
    tick(1);
    dn = 1'h0;
    tick(1);
    dn = 1'h1;
    tick(1);
    dn = 1'h0;
    up = 1'h1;
    tick(1);
    up = 1'h0;
    tick(1);
    chk("gain steps", 16'(gain), 16'h00e0);
    adl = 1'h0;
    tick(2);
    chk("alc idle", 16'(act), 16'h0000);
    up = 1'h1;
    tick(1);
    up = 1'h0;
    wr = 1'h1;
    tick(1);
    wr = 1'h0;
    adr = 1'h1;
    tick(1);
    chk("gain kept", 16'(gain), 16'h00e0);
    // Manual mode: the write is taken
    auto_level_enable = 1'h0;
    wr = 1'h1;
    tick(1);
    wr = 1'h0;
    tick(1);
    chk("gain write", 16'(gain), 16'h0040);
    $display("recording test done");
    rstn = 1'h0;
    tick(2);
    chk("gain rearm", 16'(gain), 16'h00e1);
    rstn = 1'h1;
    tick(3);
    chk("init rearm", 16'(busy), 16'h0001);
    $display("second reset test done");
    complete_run();
  end
endmodule : ccpb_clock_power_tb_top

// File: bench/ccpb_host_clocks.sv
// Host-side audio clock source for the bring-up bench
`timescale 1ns/1ns
module ccpb_host_clocks (
  input wire logic clk_i,
  input wire logic run_i,
  output logic mclk_o,
  output logic bclk_o,
  output logic fclk_o
);
  logic [3:0] cnt = 4'h0;
  // One counter keeps all three clocks in step; stopped clocks stand still low
  always_ff @(negedge clk_i) begin
    cnt <= run_i ? cnt + 4'h1 : 4'h0;
  end
  // Taps slow enough for the pin synchronisers
  assign mclk_o = cnt[1];
  assign bclk_o = cnt[2];
  assign fclk_o = cnt[3];
endmodule : ccpb_host_clocks

// File: hw/ccpb_activity.sv
// Pin clock synchroniser with edge detect and presence window
`timescale 1ns/1ns
`include "ccpb_defs.svh"

module ccpb_activity #(
  parameter int CW = 10
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic present_o
);

  logic sync_a;
  logic sync_b;
  logic last;
  logic [CW-1:0] idle;

  // Two stages; only the second stage feeds the edge detector
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last <= 1'b0;
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
      last <= sync_b;
    end
  end

  assign rise_o = sync_b & ~last;

  // Idle counter saturates; a stopped clock drops presence
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle <= `CCPB_ACT_WINDOW_CYC;
    end else if (rise_o) begin
      idle <= '0;
    end else if (idle != `CCPB_ACT_WINDOW_CYC) begin
      idle <= idle + 1'b1;
    end
  end

  assign present_o = (idle != `CCPB_ACT_WINDOW_CYC);

endmodule : ccpb_activity

// File: hw/ccpb_clock_power.sv
// Codec clock and power bring-up sequencer, top level
//
// Behaviour
// - PLL master lock within 40ms
// - PLL master: frame/bit clocks after lock
// - Master clock out invalid before lock
// - Slave lock: frame 160ms, bit 2ms
// - Slave master-clock reference lock within 40ms
// - External slave: normal once all clocks
// - External master: clocks driven after master select
// - ADC initialisation lasts 1059 sample periods
// - Level control starts from +30dB
// - Level control idle while ADC down
// - Gain retained across ADC power down
// - DAC samples are two's complement
// - Power-down resets all control state
// - PLL enable selects PLL clock mode
`timescale 1ns/1ns
`include "ccpb_defs.svh"

module ccpb_clock_power #(
  parameter int LOCK_MCLK_CYC = `CCPB_LOCK_MCLK_MS * `CCPB_CLK_KHZ,
  parameter int LOCK_FRAME_CYC = `CCPB_LOCK_FRAME_MS * `CCPB_CLK_KHZ,
  parameter int LOCK_BIT_CYC = `CCPB_LOCK_BIT_MS * `CCPB_CLK_KHZ
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic COMMON_BIAS_ENABLE_I,
  input wire logic PLL_POWER_ENABLE_I,
  input wire logic MASTER_CLOCK_OUT_ENABLE_I,
  input wire logic MASTER_SELECT_I,
  input wire logic [1:0] PLL_REFERENCE_SEL_I,
  input wire logic BIT_CLOCK_RATE_SEL_I,
  input wire logic ADC_LEFT_POWER_I,
  input wire logic ADC_RIGHT_POWER_I,
  input wire logic AUTO_LEVEL_ENABLE_I,
  input wire logic GAIN_UP_I,
  input wire logic GAIN_DOWN_I,
  input wire logic GAIN_WRITE_I,
  input wire logic [7:0] GAIN_VALUE_I,
  input wire logic [15:0] DAC_SAMPLE_I,
  input wire logic MASTER_CLOCK_INPUT_I,
  input wire logic FRAME_CLOCK_I,
  input wire logic BIT_CLOCK_I,
  output logic MASTER_CLOCK_O,
  output logic MASTER_CLOCK_OE_O,
  output logic FRAME_CLOCK_O,
  output logic FRAME_CLOCK_OE_O,
  output logic BIT_CLOCK_O,
  output logic BIT_CLOCK_OE_O,
  output logic [2:0] CLOCK_MODE_O,
  output logic LOCK_VALID_O,
  output logic NORMAL_OPERATION_O,
  output logic ADC_INIT_BUSY_O,
  output logic ADC_DATA_VALID_O,
  output logic AUTO_LEVEL_ACTIVE_O,
  output logic [7:0] INPUT_VOLUME_GAIN_O,
  output logic [15:0] DAC_LEVEL_O
);

  logic mclk_present;
  logic frame_rise;
  logic frame_present;
  logic bit_present;
  ccpb_pkg::ccpb_mode_t mode;
  ccpb_pkg::ccpb_lock_t lock_state;
  ccpb_pkg::ccpb_lock_t next_lock_state;
  logic [27:0] lock_cnt;
  logic [27:0] lock_limit;
  logic ref_present;
  logic pll_run;
  logic locked;
  logic [7:0] div;
  logic drive_clocks;
  logic int_frame;
  logic int_frame_last;
  logic sample_tick;
  logic adc_on;
  logic adc_on_last;
  logic [10:0] init_cnt;
  logic init_busy;
  logic alc_active;
  logic [7:0] gain;
  logic mclk_out;
  logic frame_out;
  logic bit_out;
  logic [15:0] dac_level;

  // Pin clocks enter through two flops each before any logic
  ccpb_activity #(.CW(10)) u_act_mclk (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .pin_i(MASTER_CLOCK_INPUT_I),
    .rise_o(),
    .present_o(mclk_present)
  );

  ccpb_activity #(.CW(10)) u_act_frame (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .pin_i(FRAME_CLOCK_I),
    .rise_o(frame_rise),
    .present_o(frame_present)
  );

  ccpb_activity #(.CW(10)) u_act_bit (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .pin_i(BIT_CLOCK_I),
    .rise_o(),
    .present_o(bit_present)
  );

  // Mode decode: PLL enable picks PLL or external clocking
  assign mode = !PLL_POWER_ENABLE_I ?
      (MASTER_SELECT_I ? ccpb_pkg::CCPB_EXT_MASTER : ccpb_pkg::CCPB_EXT_SLAVE) :
      MASTER_SELECT_I ? ccpb_pkg::CCPB_PLL_MASTER :
      (PLL_REFERENCE_SEL_I == `CCPB_REF_FRAME) ? ccpb_pkg::CCPB_PLL_SLAVE_FRAME :
      (PLL_REFERENCE_SEL_I == `CCPB_REF_BIT) ? ccpb_pkg::CCPB_PLL_SLAVE_BIT :
      ccpb_pkg::CCPB_PLL_SLAVE_MCLK;

  // Lock bound and reference presence follow the selected reference
  assign lock_limit = (mode == ccpb_pkg::CCPB_PLL_SLAVE_FRAME) ? LOCK_FRAME_CYC[27:0] :
      (mode == ccpb_pkg::CCPB_PLL_SLAVE_BIT) ? LOCK_BIT_CYC[27:0] :
      LOCK_MCLK_CYC[27:0];
  assign ref_present = (mode == ccpb_pkg::CCPB_PLL_SLAVE_FRAME) ? frame_present :
      (mode == ccpb_pkg::CCPB_PLL_SLAVE_BIT) ? bit_present : mclk_present;
  // Nothing runs without common bias; PLL also needs its reference
  assign pll_run = COMMON_BIAS_ENABLE_I & PLL_POWER_ENABLE_I & ref_present;

  // Lock sequencer: timeout to the worst-case lock time
  always_comb begin
    next_lock_state = lock_state;
    case (lock_state)
      ccpb_pkg::CCPB_LK_OFF: begin
        if (pll_run) begin
          next_lock_state = ccpb_pkg::CCPB_LK_WAIT;
        end
      end
      ccpb_pkg::CCPB_LK_WAIT: begin
        if (!pll_run) begin
          next_lock_state = ccpb_pkg::CCPB_LK_OFF;
        end else if (lock_cnt >= lock_limit - 28'h1) begin
          next_lock_state = ccpb_pkg::CCPB_LK_LOCKED;
        end
      end
      ccpb_pkg::CCPB_LK_LOCKED: begin
        if (!pll_run) begin
          next_lock_state = ccpb_pkg::CCPB_LK_OFF;
        end
      end
      default: begin
        next_lock_state = ccpb_pkg::CCPB_LK_OFF;
      end
    endcase
  end

  // Counter clears whenever lock is lost, so a new wait starts fresh
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      lock_state <= ccpb_pkg::CCPB_LK_OFF;
      lock_cnt <= '0;
    end else begin
      lock_state <= next_lock_state;
      lock_cnt <= (next_lock_state == ccpb_pkg::CCPB_LK_WAIT) ? lock_cnt + 28'h1 : '0;
    end
  end

  assign locked = (lock_state == ccpb_pkg::CCPB_LK_LOCKED);

  // Free divider from the core clock stands in for the PLL output
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      div <= '0;
    end else begin
      div <= div + 8'h01;
    end
  end

  // Which party drives frame and bit clocks
  assign drive_clocks = COMMON_BIAS_ENABLE_I &
      (((mode == ccpb_pkg::CCPB_PLL_MASTER) & locked) |
       ((mode == ccpb_pkg::CCPB_EXT_MASTER) & mclk_present));
  assign int_frame = BIT_CLOCK_RATE_SEL_I ? div[`CCPB_TAP_FRAME_64] : div[`CCPB_TAP_FRAME_32];
  // Wrong tap before lock is the deliberately invalid frequency
  assign mclk_out = locked ? div[`CCPB_TAP_MCLK_OK] : div[`CCPB_TAP_MCLK_BAD];
  assign frame_out = drive_clocks & int_frame;
  assign bit_out = drive_clocks & div[`CCPB_TAP_BIT];

  // Clock pins come from flops to avoid glitches on the gating
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      MASTER_CLOCK_O <= 1'b0;
      MASTER_CLOCK_OE_O <= 1'b0;
      FRAME_CLOCK_O <= 1'b0;
      FRAME_CLOCK_OE_O <= 1'b0;
      BIT_CLOCK_O <= 1'b0;
      BIT_CLOCK_OE_O <= 1'b0;
    end else begin
      MASTER_CLOCK_O <= MASTER_CLOCK_OUT_ENABLE_I & pll_run & mclk_out;
      MASTER_CLOCK_OE_O <= MASTER_CLOCK_OUT_ENABLE_I & pll_run;
      FRAME_CLOCK_O <= frame_out;
      FRAME_CLOCK_OE_O <= drive_clocks;
      BIT_CLOCK_O <= bit_out;
      BIT_CLOCK_OE_O <= drive_clocks;
    end
  end

  // Normal operation per mode
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      NORMAL_OPERATION_O <= 1'b0;
      LOCK_VALID_O <= 1'b0;
      CLOCK_MODE_O <= ccpb_pkg::CCPB_EXT_SLAVE;
    end else begin
      LOCK_VALID_O <= locked;
      CLOCK_MODE_O <= mode;
      case (mode)
        ccpb_pkg::CCPB_EXT_SLAVE: begin
          NORMAL_OPERATION_O <= COMMON_BIAS_ENABLE_I & mclk_present &
              frame_present & bit_present;
        end
        ccpb_pkg::CCPB_EXT_MASTER: begin
          NORMAL_OPERATION_O <= drive_clocks;
        end
        ccpb_pkg::CCPB_PLL_MASTER: begin
          NORMAL_OPERATION_O <= drive_clocks;
        end
        default: begin
          // Bias gate too: lock state trails a bias drop by one edge
          NORMAL_OPERATION_O <= COMMON_BIAS_ENABLE_I & locked;
        end
      endcase
    end
  end

  // Sample tick: internal frame when driving, else the frame pin
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      int_frame_last <= 1'b0;
      adc_on_last <= 1'b0;
    end else begin
      int_frame_last <= frame_out;
      adc_on_last <= adc_on;
    end
  end

  assign sample_tick = drive_clocks ? (frame_out & ~int_frame_last) : frame_rise;
  assign adc_on = COMMON_BIAS_ENABLE_I & (ADC_LEFT_POWER_I | ADC_RIGHT_POWER_I);

  // Initialisation counts sample periods; a stopped frame clock stalls it
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      init_cnt <= '0;
    end else if (!adc_on) begin
      init_cnt <= '0;
    end else if (!adc_on_last) begin
      init_cnt <= `CCPB_ADC_INIT_FS;
    end else if (sample_tick && init_cnt != 11'h000) begin
      init_cnt <= init_cnt - 11'h001;
    end
  end

  assign init_busy = adc_on & (~adc_on_last | (init_cnt != 11'h000));
  // Level control only with the path up and initialised
  assign alc_active = AUTO_LEVEL_ENABLE_I & adc_on & ~init_busy;

  // Gain starts at +30dB from reset and is kept while the ADC is down
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      gain <= `CCPB_GAIN_DEFAULT;
    end else if (alc_active) begin
      if (GAIN_DOWN_I && gain != `CCPB_GAIN_MIN) begin
        gain <= gain - 8'h01;
      end else if (GAIN_UP_I && !GAIN_DOWN_I && gain != `CCPB_GAIN_MAX) begin
        gain <= gain + 8'h01;
      end
    end else if (GAIN_WRITE_I && !AUTO_LEVEL_ENABLE_I) begin
      gain <= GAIN_VALUE_I;
    end
  end

  // Two's complement to offset binary: 7fff top, 8000 bottom
  assign dac_level = {~DAC_SAMPLE_I[15], DAC_SAMPLE_I[14:0]};

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ADC_INIT_BUSY_O <= 1'b0;
      ADC_DATA_VALID_O <= 1'b0;
      AUTO_LEVEL_ACTIVE_O <= 1'b0;
      INPUT_VOLUME_GAIN_O <= `CCPB_GAIN_DEFAULT;
      DAC_LEVEL_O <= '0;
    end else begin
      ADC_INIT_BUSY_O <= init_busy;
      ADC_DATA_VALID_O <= adc_on & ~init_busy;
      AUTO_LEVEL_ACTIVE_O <= alc_active;
      INPUT_VOLUME_GAIN_O <= gain;
      DAC_LEVEL_O <= dac_level;
    end
  end

endmodule : ccpb_clock_power

// File: hw/ccpb_defs.svh
// Constants for the codec clock and power bring-up sequencer
`ifndef CCPB_DEFS_SVH
`define CCPB_DEFS_SVH

// Clock rate
`define CCPB_CLK_KHZ 100000
`define CCPB_CLK_PERIOD_NS 10

// Least low time of the power-down pin, and its count rounded up
`define CCPB_RESET_LOW_NS 150
`define CCPB_RESET_LOW_CYC ((`CCPB_RESET_LOW_NS + `CCPB_CLK_PERIOD_NS - 1) / `CCPB_CLK_PERIOD_NS)

// Longest lock times per reference, in ms
`define CCPB_LOCK_MCLK_MS 40
`define CCPB_LOCK_FRAME_MS 160
`define CCPB_LOCK_BIT_MS 2

// Reference select codes
`define CCPB_REF_MCLK 2'h0
`define CCPB_REF_FRAME 2'h1
`define CCPB_REF_BIT 2'h2

// Initialisation cycle length in sample periods
`define CCPB_ADC_INIT_FS 11'h423

// Input volume reset value, +30dB
`define CCPB_GAIN_DEFAULT 8'he1
`define CCPB_GAIN_MAX 8'hff
`define CCPB_GAIN_MIN 8'h00

// Clock activity window, in cycles since the last rising edge
`define CCPB_ACT_WINDOW_CYC 10'h3ff

// Divider taps: master clock after and before lock, bit clock, frame clock
`define CCPB_TAP_MCLK_OK 0
`define CCPB_TAP_MCLK_BAD 2
`define CCPB_TAP_BIT 1
`define CCPB_TAP_FRAME_64 7
`define CCPB_TAP_FRAME_32 6

`endif

// File: hw/ccpb_pkg.sv
// Types for the codec clock and power bring-up sequencer
package ccpb_pkg;

  typedef enum logic [2:0] {
    CCPB_EXT_SLAVE = 3'h0,
    CCPB_EXT_MASTER = 3'h1,
    CCPB_PLL_MASTER = 3'h2,
    CCPB_PLL_SLAVE_FRAME = 3'h3,
    CCPB_PLL_SLAVE_BIT = 3'h4,
    CCPB_PLL_SLAVE_MCLK = 3'h5
  } ccpb_mode_t;

  typedef enum logic [1:0] {
    CCPB_LK_OFF = 2'h0,
    CCPB_LK_WAIT = 2'h1,
    CCPB_LK_LOCKED = 2'h2
  } ccpb_lock_t;

endpackage : ccpb_pkg
